// >>> rtl/lic_defines.svh
`ifndef LIC_DEFINES_SVH
`define LIC_DEFINES_SVH

// Management register addresses
`define LIC_ADDR_MODE_CTRL 5'h1b
`define LIC_ADDR_FUNC_SEL 5'h1c

// Reset values and writable bits
`define LIC_MODE_CTRL_RST 16'h0001
`define LIC_MODE_CTRL_WMASK 16'hfcfd
`define LIC_FUNC_SEL_RST 16'hf4f0

// Mode control fields
`define LIC_TC_GIG_BIT 15
`define LIC_TC_LINK_BIT 14
`define LIC_EXT_LSB 10
`define LIC_PAUSE_MSB 7
`define LIC_PAUSE_LSB 4
`define LIC_DUR_MSB 3
`define LIC_DUR_LSB 2
`define LIC_STRETCH_EN_BIT 0

// Indicator index: 0 gigabit, 1 fast speed, 2 link, 3 traffic
`define LIC_IND_GIG 0
`define LIC_IND_FAST 1
`define LIC_IND_LINK 2
`define LIC_IND_TRAFFIC 3

// Speed status encoding
`define LIC_SPEED_1000 2'h2
`define LIC_SPEED_100 2'h1
`define LIC_SPEED_10 2'h0

// Timing
`define LIC_CLK_KHZ 125000
`define LIC_STRETCH_28_MS 28
`define LIC_STRETCH_60_MS 60
`define LIC_STRETCH_100_MS 100
`define LIC_BLINK_PERIOD_MS 512
`define LIC_BLINK_STEPS 8
`define LIC_STRETCH_28_CYC (`LIC_STRETCH_28_MS * `LIC_CLK_KHZ)
`define LIC_STRETCH_60_CYC (`LIC_STRETCH_60_MS * `LIC_CLK_KHZ)
`define LIC_STRETCH_100_CYC (`LIC_STRETCH_100_MS * `LIC_CLK_KHZ)
`define LIC_BLINK_STEP_CYC (`LIC_BLINK_PERIOD_MS * `LIC_CLK_KHZ / `LIC_BLINK_STEPS)
`define LIC_BLINK_PATTERN 8'h55

`endif

// >>> rtl/lic_event_stretch.sv
`timescale 1ns/1ps
`default_nettype none
`include "lic_defines.svh"

module lic_event_stretch #(
	parameter logic [23:0] CYC_28 = 24'(`LIC_STRETCH_28_CYC),
	parameter logic [23:0] CYC_60 = 24'(`LIC_STRETCH_60_CYC),
	parameter logic [23:0] CYC_100 = 24'(`LIC_STRETCH_100_CYC)
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic event_in,
	input wire logic enable_in,
	input wire logic [1:0] duration_sel_in,
	output logic stretched_out
);
	logic [23:0] cnt_r;
	logic [23:0] cnt_nxt;
	logic [23:0] len;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	always_comb begin
		case (duration_sel_in)
			2'h0: len = CYC_28;
			2'h1: len = CYC_60;
			default: len = CYC_100; // Reserved code treated as longest
		endcase
		cnt_nxt = cnt_r;
		if (!enable_in) begin
			cnt_nxt = 24'h0;
		end else if (event_in) begin
			cnt_nxt = len;
		end else if (cnt_r != 24'h0) begin
			cnt_nxt = cnt_r - 24'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cnt_r <= 24'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign stretched_out = event_in | (enable_in && cnt_r != 24'h0);

	property p_no_stretch_when_off;
		!enable_in |=> cnt_r == 24'h0;
	endproperty
	a_no_stretch_when_off: assert property (p_no_stretch_when_off) else $error("stretch while off");

	property p_hold_after_event;
		enable_in && event_in ##1 enable_in && !event_in |-> stretched_out;
	endproperty
	a_hold_after_event: assert property (p_hold_after_event) else $error("event not held");

	property p_load_28;
		enable_in && event_in && duration_sel_in == 2'h0 |=> cnt_r == CYC_28;
	endproperty
	a_load_28: assert property (p_load_28) else $error("wrong 28 ms load");

	c_stretch_tail: cover property (enable_in && event_in ##1 !event_in [*3] ##0 stretched_out);
endmodule
`default_nettype wire

// >>> rtl/lic_indicator_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "lic_defines.svh"

module lic_indicator_control #(
	parameter logic [23:0] STRETCH_28_CYC = 24'(`LIC_STRETCH_28_CYC),
	parameter logic [23:0] STRETCH_60_CYC = 24'(`LIC_STRETCH_60_CYC),
	parameter logic [23:0] STRETCH_100_CYC = 24'(`LIC_STRETCH_100_CYC),
	parameter logic [22:0] BLINK_STEP_CYC = 23'(`LIC_BLINK_STEP_CYC)
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [4:0] mgmt_addr_in,
	input wire logic mgmt_wr_in,
	input wire logic [15:0] mgmt_wdata_in,
	output logic [15:0] mgmt_rdata_out,
	input wire logic link_up_in,
	input wire logic [1:0] speed_in,
	input wire logic full_duplex_in,
	input wire logic transmit_in,
	input wire logic receive_in,
	input wire logic collision_in,
	output logic gigabit_indicator_out,
	output logic fast_speed_indicator_out,
	output logic link_indicator_out,
	output logic traffic_indicator_out
);
	logic [15:0] mode_r;
	logic [15:0] mode_nxt;
	logic [15:0] func_r;
	logic [15:0] func_nxt;
	logic [15:0] rdata_nxt;
	logic [3:0] ind_r;
	logic [3:0] ind_nxt;
	logic [3:0] fn;
	logic [2:0] raw_ev;
	logic [2:0] str_ev;
	lic_pkg::lic_blink_state_t blink_state_r;
	lic_pkg::lic_blink_state_t blink_state_nxt;
	logic [22:0] step_cnt_r;
	logic [22:0] step_cnt_nxt;
	logic [2:0] bit_idx_r;
	logic [2:0] bit_idx_nxt;
	logic [3:0] pause_idx_r;
	logic [3:0] pause_idx_nxt;
	logic blink;
	logic step_tick;
	logic [3:0] pause_cnt;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	// Register file
	always_comb begin
		mode_nxt = mode_r;
		func_nxt = func_r;
		rdata_nxt = 16'h0;
		if (mgmt_addr_in == `LIC_ADDR_MODE_CTRL) begin
			rdata_nxt = mode_r;
			if (mgmt_wr_in) begin
				// Reserved bits stay zero
				mode_nxt = mgmt_wdata_in & `LIC_MODE_CTRL_WMASK;
			end
		end else if (mgmt_addr_in == `LIC_ADDR_FUNC_SEL) begin
			rdata_nxt = func_r;
			if (mgmt_wr_in) begin
				func_nxt = mgmt_wdata_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mode_r <= `LIC_MODE_CTRL_RST;
			func_r <= `LIC_FUNC_SEL_RST;
			mgmt_rdata_out <= 16'h0;
		end else begin
			mode_r <= mode_nxt;
			func_r <= func_nxt;
			mgmt_rdata_out <= rdata_nxt;
		end
	end

	property p_func_write;
		mgmt_wr_in && mgmt_addr_in == `LIC_ADDR_FUNC_SEL |=> func_r == $past(mgmt_wdata_in);
	endproperty
	a_func_write: assert property (p_func_write) else $error("function write lost");

	// Event stretching for transmit, receive and collision
	assign raw_ev = {collision_in, receive_in, transmit_in};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_stretch
			lic_event_stretch #(
				.CYC_28(STRETCH_28_CYC),
				.CYC_60(STRETCH_60_CYC),
				.CYC_100(STRETCH_100_CYC)
			) u_stretch (
				.clk_in(clk_in),
				.sys_rst_in(sys_rst_in),
				.event_in(raw_ev[gi]),
				.enable_in(mode_r[`LIC_STRETCH_EN_BIT]),
				.duration_sel_in(mode_r[`LIC_DUR_MSB:`LIC_DUR_LSB]),
				.stretched_out(str_ev[gi])
			);
		end
	endgenerate

	// Blink generator: eight pattern steps, then an optional pause
	assign pause_cnt = mode_r[`LIC_PAUSE_MSB:`LIC_PAUSE_LSB];
	assign step_tick = step_cnt_r == BLINK_STEP_CYC - 23'h1;
	assign blink = (blink_state_r == lic_pkg::LIC_BLINK_PATTERN)
		&& 1'(`LIC_BLINK_PATTERN >> bit_idx_r);

	always_comb begin
		blink_state_nxt = blink_state_r;
		bit_idx_nxt = bit_idx_r;
		pause_idx_nxt = pause_idx_r;
		step_cnt_nxt = step_tick ? 23'h0 : step_cnt_r + 23'h1;
		if (step_tick) begin
			case (blink_state_r)
				lic_pkg::LIC_BLINK_PATTERN: begin
					bit_idx_nxt = bit_idx_r + 3'h1;
					if (bit_idx_r == 3'h7 && pause_cnt != 4'h0) begin
						blink_state_nxt = lic_pkg::LIC_BLINK_PAUSE;
						pause_idx_nxt = 4'h0;
					end
				end
				lic_pkg::LIC_BLINK_PAUSE: begin
					pause_idx_nxt = pause_idx_r + 4'h1;
					if (pause_idx_r >= pause_cnt - 4'h1) begin
						blink_state_nxt = lic_pkg::LIC_BLINK_PATTERN;
					end
				end
				default: blink_state_nxt = lic_pkg::LIC_BLINK_PATTERN;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			blink_state_r <= lic_pkg::LIC_BLINK_PATTERN;
			step_cnt_r <= 23'h0;
			bit_idx_r <= 3'h0;
			pause_idx_r <= 4'h0;
		end else begin
			blink_state_r <= blink_state_nxt;
			step_cnt_r <= step_cnt_nxt;
			bit_idx_r <= bit_idx_nxt;
			pause_idx_r <= pause_idx_nxt;
		end
	end

	property p_no_pause_when_zero;
		pause_cnt == 4'h0 && blink_state_r == lic_pkg::LIC_BLINK_PATTERN
			|=> blink_state_r == lic_pkg::LIC_BLINK_PATTERN;
	endproperty
	a_no_pause_when_zero: assert property (p_no_pause_when_zero) else $error("bad pause");

	c_pause: cover property (blink_state_r == lic_pkg::LIC_BLINK_PAUSE);

	// Function decode
	function automatic logic lic_decode(input logic ext, input logic [3:0] code,
		input logic lk, input logic [1:0] spd, input logic fdx, input logic tx,
		input logic rx, input logic col, input logic blk);
		logic g1000;
		logic g100;
		logic g10;
		logic act;
		logic res;
		g1000 = lk && spd == `LIC_SPEED_1000;
		g100 = lk && spd == `LIC_SPEED_100;
		g10 = lk && spd == `LIC_SPEED_10;
		act = tx | rx;
		res = 1'b0;
		if (ext) begin
			case (code)
				4'h0: res = g10 | g100;
				4'h4: res = g1000 & (!act | blk);
				4'h5: res = (g10 | g100) & (!act | blk);
				default: res = 1'b0;
			endcase
		end else begin
			case (code)
				4'h0: res = g1000;
				4'h1: res = g100;
				4'h2: res = g10;
				4'h3: res = g1000 | (g100 & blk);
				4'h4: res = lk;
				4'h5: res = tx;
				4'h6: res = rx;
				4'h7: res = act;
				4'h8: res = fdx;
				4'h9: res = col;
				4'ha: res = lk & (!act | blk);
				4'hb: res = lk & (!rx | blk);
				4'hc: res = fdx & (!rx | blk);
				4'hd: res = blk;
				4'he: res = 1'b1;
				default: res = 1'b0;
			endcase
		end
		return res;
	endfunction

	generate
		for (gi = 0; gi < 4; gi++) begin : g_func
			assign fn[gi] = lic_decode(mode_r[`LIC_EXT_LSB + gi], func_r[4 * gi +: 4],
				link_up_in, speed_in, full_duplex_in, str_ev[0], str_ev[1], str_ev[2], blink);
		end
	endgenerate

	always_comb begin
		ind_nxt = fn;
		if (mode_r[`LIC_TC_GIG_BIT]) begin
			ind_nxt[`LIC_IND_GIG] = fn[`LIC_IND_GIG] & fn[`LIC_IND_FAST];
		end
		if (mode_r[`LIC_TC_LINK_BIT]) begin
			ind_nxt[`LIC_IND_LINK] = fn[`LIC_IND_LINK] & fn[`LIC_IND_TRAFFIC];
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ind_r <= 4'h0;
		end else begin
			ind_r <= ind_nxt;
		end
	end

	assign gigabit_indicator_out = ind_r[`LIC_IND_GIG];
	assign fast_speed_indicator_out = ind_r[`LIC_IND_FAST];
	assign link_indicator_out = ind_r[`LIC_IND_LINK];
	assign traffic_indicator_out = ind_r[`LIC_IND_TRAFFIC];

	property p_tc_gig;
		mode_r[`LIC_TC_GIG_BIT] && !fn[`LIC_IND_FAST] |=> !gigabit_indicator_out;
	endproperty
	a_tc_gig: assert property (p_tc_gig) else $error("gigabit pair not gated");

	property p_tc_link;
		mode_r[`LIC_TC_LINK_BIT] |=> link_indicator_out == $past(fn[`LIC_IND_LINK] & fn[`LIC_IND_TRAFFIC]);
	endproperty
	a_tc_link: assert property (p_tc_link) else $error("link pair not gated");

	property p_forced_off;
		!mode_r[`LIC_EXT_LSB + 3] && func_r[15:12] == 4'hf |=> !traffic_indicator_out;
	endproperty
	a_forced_off: assert property (p_forced_off) else $error("traffic not off");

	property p_forced_on;
		!mode_r[`LIC_EXT_LSB + 2] && func_r[11:8] == 4'he && !mode_r[`LIC_TC_LINK_BIT]
			|=> link_indicator_out;
	endproperty
	a_forced_on: assert property (p_forced_on) else $error("link not on");

	property p_link_code;
		!mode_r[`LIC_EXT_LSB + 2] && func_r[11:8] == 4'h4 && !mode_r[`LIC_TC_LINK_BIT]
			|=> link_indicator_out == $past(link_up_in);
	endproperty
	a_link_code: assert property (p_link_code) else $error("link code wrong");

	property p_gig_speed;
		!mode_r[`LIC_EXT_LSB] && func_r[3:0] == 4'h0 && !mode_r[`LIC_TC_GIG_BIT]
			|=> gigabit_indicator_out == $past(link_up_in && speed_in == `LIC_SPEED_1000);
	endproperty
	a_gig_speed: assert property (p_gig_speed) else $error("gigabit code wrong");

	c_two_colour: cover property (mode_r[`LIC_TC_LINK_BIT] && link_indicator_out);
	c_blinking: cover property (fn[`LIC_IND_TRAFFIC] ##1 !fn[`LIC_IND_TRAFFIC]);
endmodule
`default_nettype wire

// >>> rtl/lic_pkg.sv
package lic_pkg;
	typedef enum logic [1:0] {
		LIC_BLINK_PATTERN = 2'h1,
		LIC_BLINK_PAUSE = 2'h2
	} lic_blink_state_t;
endpackage

// >>> sim/lic_indicator_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lic_defines.svh"

module lic_indicator_control_tb;
	logic clk_in, sys_rst_in, mgmt_wr_in, link_up_in, full_duplex_in;
	logic transmit_in, receive_in, collision_in, led_clr;
	logic [4:0] mgmt_addr_in;
	logic [15:0] mgmt_wdata_in, mgmt_rdata_out, link_lit, v;
	logic [1:0] speed_in;
	logic [3:0] leds;
	int failures, check_count;

	lic_indicator_control #(.STRETCH_28_CYC(24'h4), .STRETCH_60_CYC(24'h8),
		.STRETCH_100_CYC(24'hc), .BLINK_STEP_CYC(23'h4)) dut_u (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .mgmt_addr_in(mgmt_addr_in),
		.mgmt_wr_in(mgmt_wr_in), .mgmt_wdata_in(mgmt_wdata_in),
		.mgmt_rdata_out(mgmt_rdata_out), .link_up_in(link_up_in), .speed_in(speed_in),
		.full_duplex_in(full_duplex_in), .transmit_in(transmit_in),
		.receive_in(receive_in), .collision_in(collision_in),
		.gigabit_indicator_out(leds[0]), .fast_speed_indicator_out(leds[1]),
		.link_indicator_out(leds[2]), .traffic_indicator_out(leds[3]));
	lic_led_model led_u (.clk_in(clk_in), .clr_in(led_clr), .led_in(leds),
		.link_lit_out(link_lit));

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	task automatic tally_and_finish;
		$display("Checks %0d, failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in);
		mgmt_addr_in <= a;
		mgmt_wr_in <= 1'b1;
		mgmt_wdata_in <= d;
		@(posedge clk_in);
		mgmt_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_in);
		mgmt_addr_in <= a;
		repeat (2) @(posedge clk_in);
		#1 d = mgmt_rdata_out;
	endtask

	// Status packed as link, speed, duplex, tx, rx, collision
	task automatic status(input logic [6:0] s);
		@(posedge clk_in);
		{link_up_in, speed_in, full_duplex_in, transmit_in, receive_in, collision_in} <= s;
		repeat (3) @(posedge clk_in);
		#1;
	endtask

	task automatic code_case(input logic ext, input logic [3:0] c, input logic [6:0] s,
		input logic e);
		wr(`LIC_ADDR_MODE_CTRL, ext ? 16'h1000 : 16'h0000);
		wr(`LIC_ADDR_FUNC_SEL, {4'hf, c, 8'hff});
		status(s);
		chk(16'(leds[2]), 16'(e));
	endtask

	task automatic t_regs;
		rd(`LIC_ADDR_MODE_CTRL, v);
		chk(v, 16'h0001);
		rd(`LIC_ADDR_FUNC_SEL, v);
		chk(v, 16'hf4f0);
		rd(5'h00, v);
		chk(v, 16'h0000);
		wr(`LIC_ADDR_MODE_CTRL, 16'hffff);
		rd(`LIC_ADDR_MODE_CTRL, v);
		chk(v, 16'hfcfd);
		wr(`LIC_ADDR_FUNC_SEL, 16'h1234);
		wr(5'h1d, 16'hffff);
		rd(`LIC_ADDR_FUNC_SEL, v);
		chk(v, 16'h1234);
	endtask

	task automatic t_codes;
		code_case(1'b0, 4'h0, 7'h60, 1'b1);
		code_case(1'b0, 4'h0, 7'h48, 1'b0);
		code_case(1'b0, 4'h1, 7'h50, 1'b1);
		code_case(1'b0, 4'h2, 7'h40, 1'b1);
		code_case(1'b0, 4'h3, 7'h60, 1'b1);
		code_case(1'b0, 4'h4, 7'h40, 1'b1);
		code_case(1'b0, 4'h4, 7'h00, 1'b0);
		code_case(1'b0, 4'h5, 7'h44, 1'b1);
		code_case(1'b0, 4'h6, 7'h42, 1'b1);
		code_case(1'b0, 4'h7, 7'h42, 1'b1);
		code_case(1'b0, 4'h7, 7'h41, 1'b0);
		code_case(1'b0, 4'h8, 7'h08, 1'b1);
		code_case(1'b0, 4'h9, 7'h01, 1'b1);
		code_case(1'b0, 4'ha, 7'h40, 1'b1);
		code_case(1'b0, 4'hb, 7'h40, 1'b1);
		code_case(1'b0, 4'hc, 7'h08, 1'b1);
		code_case(1'b0, 4'he, 7'h00, 1'b1);
		code_case(1'b0, 4'hf, 7'h7f, 1'b0);
		code_case(1'b1, 4'h0, 7'h48, 1'b1);
		code_case(1'b1, 4'h0, 7'h60, 1'b0);
		code_case(1'b1, 4'h4, 7'h60, 1'b1);
		code_case(1'b1, 4'h5, 7'h40, 1'b1);
		code_case(1'b1, 4'h1, 7'h7f, 1'b0);
	endtask

	task automatic t_pairs;
		status(7'h40);
		wr(`LIC_ADDR_MODE_CTRL, 16'h4000);
		wr(`LIC_ADDR_FUNC_SEL, 16'he4ff);
		status(7'h40);
		chk(16'(leds), 16'h0c);
		wr(`LIC_ADDR_FUNC_SEL, 16'hf4ff);
		status(7'h40);
		chk(16'(leds), 16'h00);
		wr(`LIC_ADDR_MODE_CTRL, 16'h8000);
		wr(`LIC_ADDR_FUNC_SEL, 16'hffee);
		status(7'h40);
		chk(16'(leds), 16'h03);
		wr(`LIC_ADDR_FUNC_SEL, 16'hfffe);
		status(7'h40);
		chk(16'(leds), 16'h00);
		wr(`LIC_ADDR_MODE_CTRL, 16'h0000);
		status(7'h40);
		chk(16'(leds), 16'h01);
	endtask

	task automatic pulse_tx;
		@(posedge clk_in);
		transmit_in <= 1'b1;
		@(posedge clk_in);
		transmit_in <= 1'b0;
	endtask

	task automatic t_stretch;
		int n;
		for (int d = 0; d < 3; d++) begin
			n = 4 + 4 * d;
			wr(`LIC_ADDR_MODE_CTRL, {12'h000, 2'(d), 2'b01});
			wr(`LIC_ADDR_FUNC_SEL, 16'hf5ff);
			status(7'h00);
			pulse_tx();
			repeat (n) @(posedge clk_in);
			#1 chk(16'(leds[2]), 16'h1);
			@(posedge clk_in);
			#1 chk(16'(leds[2]), 16'h0);
		end
		// Second event inside the window must push the release out
		wr(`LIC_ADDR_MODE_CTRL, 16'h0001);
		pulse_tx();
		repeat (2) @(posedge clk_in);
		pulse_tx();
		repeat (3) @(posedge clk_in);
		#1 chk(16'(leds[2]), 16'h1);
		wr(`LIC_ADDR_MODE_CTRL, 16'h0000);
		pulse_tx();
		repeat (3) @(posedge clk_in);
		#1 chk(16'(leds[2]), 16'h0);
	endtask

	task automatic blink_duty(input logic [3:0] pause, input int period);
		wr(`LIC_ADDR_MODE_CTRL, {8'h00, pause, 4'h0});
		wr(`LIC_ADDR_FUNC_SEL, 16'hfdff);
		repeat (period) @(posedge clk_in);
		led_clr <= 1'b1;
		@(posedge clk_in);
		led_clr <= 1'b0;
		repeat (period) @(posedge clk_in);
		#1 chk(link_lit, 16'h0010);
	endtask

	initial begin
		{sys_rst_in, mgmt_wr_in, link_up_in, full_duplex_in} = 4'b1000;
		{transmit_in, receive_in, collision_in, led_clr} = 4'b0000;
		mgmt_addr_in = 5'h00;
		mgmt_wdata_in = 16'h0000;
		speed_in = 2'h3;
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_regs();
		t_codes();
		t_pairs();
		t_stretch();
		blink_duty(4'h0, 32);
		blink_duty(4'h2, 40);
		tally_and_finish();
	end

	// Full run needs about 500 cycles
	initial begin
		#200000;
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire

// >>> sim/lic_led_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "lic_defines.svh"

// External lamp bank; counts lit cycles of the link lamp so blink duty can be judged
module lic_led_model (
	input wire logic clk_in,
	input wire logic clr_in,
	input wire logic [3:0] led_in,
	output logic [15:0] link_lit_out
);
	always_ff @(posedge clk_in) begin
		if (clr_in) begin
			link_lit_out <= 16'h0;
		end else if (led_in[`LIC_IND_LINK] === 1'b1) begin
			link_lit_out <= link_lit_out + 16'h1;
		end
	end
endmodule
`default_nettype wire
